// *** src/srl_latch_top.sv ***
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Latch takes active-high set/reset at the next sys_clk edge.
// - Set and reset together give reset.
// - Software set bit pulses one cycle.
// - Software reset bit pulses one cycle.
// - Pulse bits read back as zero.
// - Divider field picks period 4 to 512.
// - Top control bit gates both output pin enables.
// - True output pin driven when enabled.
// - Inverted output pin driven when enabled.
// - Input pin sets or resets when enabled.
// - Periodic pulse sets or resets when enabled.
// - Comparator two sets or resets when enabled.
// - Comparator one sets or resets when enabled.
// - Comparator inputs use synchronised results.
// - Latch state not initialised by reset.
module srl_latch_top (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Latch sources
   input wire logic latch_external_input,
   input wire logic synced_cmp_one_result,
   input wire logic synced_cmp_two_result,
   // Latch outputs
   output logic latch_true_pin,
   output logic latch_true_pin_oe,
   output logic latch_inverted_pin,
   output logic latch_inverted_pin_oe
);
   logic [7:0] ctrl_q;
   logic [7:0] src_en_q;
   logic sw_set_q;
   logic sw_reset_q;
   logic latch_q;
   logic wr_pend_q;
   logic [11:0] addr_q;
   logic [31:0] rdata_q;
   logic addr_phase;
   logic [2:0] sync_lv;
   logic pin_lv;
   logic cmp1_lv;
   logic cmp2_lv;
   logic periodic_pulse;
   logic set_in;
   logic reset_in;
   logic latch_module_enable;
   logic [2:0] periodic_pulse_divider_select;
   logic true_output_pin_enable;
   logic inverted_output_pin_enable;
   logic wr_main;
   logic wr_src;

   function automatic logic [31:0] read_mux(input logic [11:0] a, input logic [7:0] c,
                                            input logic [7:0] s, input logic q);
      read_mux = 32'h0000_0000;
      case (a)
         srl_pkg::ADDR_CONTROL_MAIN: begin
            read_mux = {24'h00_0000, c[7:2], 2'b00};
         end
         srl_pkg::ADDR_SOURCE_ENABLES: begin
            read_mux = {24'h00_0000, s};
         end
         srl_pkg::ADDR_STATUS: begin
            read_mux = {31'h0000_0000, q};
         end
         default: begin
            read_mux = 32'h0000_0000;
         end
      endcase
   endfunction

   assign latch_module_enable = ctrl_q[srl_pkg::MODULE_ENABLE_BIT];
   assign periodic_pulse_divider_select = ctrl_q[srl_pkg::DIVIDER_SELECT_LSB +: 3];
   assign true_output_pin_enable = ctrl_q[srl_pkg::TRUE_OUT_EN_BIT];
   assign inverted_output_pin_enable = ctrl_q[srl_pkg::INV_OUT_EN_BIT];

   // Bus: zero wait states, every transfer answered OKAY.
   assign addr_phase = hsel && hready && (htrans == srl_pkg::HTRANS_NONSEQ ||
                                          htrans == srl_pkg::HTRANS_SEQ);
   assign hreadyout = 1'b1;
   assign hresp = srl_pkg::HRESP_OKAY;
   assign hrdata = rdata_q;
   assign wr_main = wr_pend_q && addr_q == srl_pkg::ADDR_CONTROL_MAIN;
   assign wr_src = wr_pend_q && addr_q == srl_pkg::ADDR_SOURCE_ENABLES;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wr_pend_q <= 1'b0;
         addr_q <= 12'h000;
      end else begin
         wr_pend_q <= addr_phase && hwrite;
         addr_q <= addr_phase ? {haddr[11:2], 2'b00} : addr_q;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rdata_q <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         rdata_q <= read_mux({haddr[11:2], 2'b00}, ctrl_q, src_en_q, latch_q);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ctrl_q <= srl_pkg::CONTROL_MAIN_RST;
      end else if (wr_main) begin
         ctrl_q <= {hwdata[7:2], 2'b00};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         src_en_q <= srl_pkg::SOURCE_ENABLES_RST;
      end else if (wr_src) begin
         src_en_q <= hwdata[7:0];
      end
   end

   // Pulse bits: a write of one lasts exactly one cycle, a zero does nothing.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sw_set_q <= 1'b0;
         sw_reset_q <= 1'b0;
      end else begin
         sw_set_q <= wr_main && hwdata[srl_pkg::SW_SET_BIT];
         sw_reset_q <= wr_main && hwdata[srl_pkg::SW_RESET_BIT];
      end
   end

   srl_sync2 u_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .async_in({latch_external_input, synced_cmp_two_result, synced_cmp_one_result}),
      .sync_out(sync_lv)
   );
   assign pin_lv = sync_lv[2];
   assign cmp2_lv = sync_lv[1];
   assign cmp1_lv = sync_lv[0];

   srl_pulse_div u_div (
      .sys_clk(sys_clk),
      .reset(reset),
      .periodic_pulse_divider_select(periodic_pulse_divider_select),
      .pulse(periodic_pulse)
   );

   assign set_in = sw_set_q |
                   (src_en_q[srl_pkg::PIN_SET_EN_BIT] & pin_lv) |
                   (src_en_q[srl_pkg::PERIODIC_SET_EN_BIT] & periodic_pulse) |
                   (src_en_q[srl_pkg::CMP_TWO_SET_EN_BIT] & cmp2_lv) |
                   (src_en_q[srl_pkg::CMP_ONE_SET_EN_BIT] & cmp1_lv);
   assign reset_in = sw_reset_q |
                     (src_en_q[srl_pkg::PIN_RESET_EN_BIT] & pin_lv) |
                     (src_en_q[srl_pkg::PERIODIC_RESET_EN_BIT] & periodic_pulse) |
                     (src_en_q[srl_pkg::CMP_TWO_RESET_EN_BIT] & cmp2_lv) |
                     (src_en_q[srl_pkg::CMP_ONE_RESET_EN_BIT] & cmp1_lv);

   // The latch storage ignores the bus reset so its state stays unknown until
   // firmware sets or resets it.
   always_ff @(posedge sys_clk) begin
      if (reset_in) begin
         latch_q <= 1'b0;
      end else if (set_in) begin
         latch_q <= 1'b1;
      end
   end

   // Each output is forced low with its enable off until both the module and that pin are enabled.
   assign latch_true_pin_oe = latch_module_enable & true_output_pin_enable;
   assign latch_inverted_pin_oe = latch_module_enable & inverted_output_pin_enable;
   assign latch_true_pin = latch_true_pin_oe & latch_q;
   assign latch_inverted_pin = latch_inverted_pin_oe & ~latch_q;

   a_reset_wins: assert property (@(posedge sys_clk) disable iff (reset)
      reset_in && set_in |=> !latch_q)
      else $error("reset did not dominate set");
   a_set_takes: assert property (@(posedge sys_clk) disable iff (reset)
      set_in && !reset_in |=> latch_q)
      else $error("set input did not set latch");
   a_sw_set_one: assert property (@(posedge sys_clk) disable iff (reset)
      wr_main && hwdata[srl_pkg::SW_SET_BIT] |=> sw_set_q ##1 !sw_set_q)
      else $error("software set pulse not one cycle");
   a_sw_reset_one: assert property (@(posedge sys_clk) disable iff (reset)
      wr_main && hwdata[srl_pkg::SW_RESET_BIT] && !set_in |=> sw_reset_q ##1 !latch_q)
      else $error("software reset pulse failed");
   a_pulse_reads: assert property (@(posedge sys_clk) disable iff (reset)
      addr_phase && !hwrite && haddr[11:2] == srl_pkg::ADDR_CONTROL_MAIN[11:2]
      |=> rdata_q[1:0] == 2'b00)
      else $error("pulse bits read nonzero");
   a_true_pin_en: assert property (@(posedge sys_clk) disable iff (reset)
      latch_true_pin_oe == (ctrl_q[7] && ctrl_q[3]))
      else $error("true pin enable wrong");
   a_inv_pin_val: assert property (@(posedge sys_clk) disable iff (reset)
      latch_inverted_pin_oe |-> latch_inverted_pin == !latch_q)
      else $error("inverted pin value wrong");
   a_pin_sets: assert property (@(posedge sys_clk) disable iff (reset)
      latch_external_input [*3] ##0 (src_en_q == 8'h80 && !sw_reset_q)
      |=> latch_q)
      else $error("input pin failed to set latch");
   a_cmp_reset: assert property (@(posedge sys_clk) disable iff (reset)
      src_en_q == 8'h01 && cmp1_lv |=> !latch_q)
      else $error("comparator one failed to reset latch");

   c_sw_set: cover property (@(posedge sys_clk) disable iff (reset) sw_set_q ##1 latch_q);
   c_both: cover property (@(posedge sys_clk) disable iff (reset) set_in && reset_in);
   c_periodic: cover property (@(posedge sys_clk) disable iff (reset)
      periodic_pulse && src_en_q[srl_pkg::PERIODIC_SET_EN_BIT]);
   c_pins_on: cover property (@(posedge sys_clk) disable iff (reset)
      latch_true_pin_oe && latch_inverted_pin_oe);
endmodule
`default_nettype wire

// *** src/srl_pkg.sv ***
package srl_pkg;
   // Register byte addresses on the AHB-Lite bus.
   localparam logic [11:0] ADDR_CONTROL_MAIN = 12'h000;
   localparam logic [11:0] ADDR_SOURCE_ENABLES = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   // Reset values.
   localparam logic [7:0] CONTROL_MAIN_RST = 8'h00;
   localparam logic [7:0] SOURCE_ENABLES_RST = 8'h00;
   // Field positions of latch_control_main.
   localparam int MODULE_ENABLE_BIT = 7;
   localparam int DIVIDER_SELECT_LSB = 4;
   localparam int TRUE_OUT_EN_BIT = 3;
   localparam int INV_OUT_EN_BIT = 2;
   localparam int SW_SET_BIT = 1;
   localparam int SW_RESET_BIT = 0;
   // Field positions of latch_source_enables.
   localparam int PIN_SET_EN_BIT = 7;
   localparam int PERIODIC_SET_EN_BIT = 6;
   localparam int CMP_TWO_SET_EN_BIT = 5;
   localparam int CMP_ONE_SET_EN_BIT = 4;
   localparam int PIN_RESET_EN_BIT = 3;
   localparam int PERIODIC_RESET_EN_BIT = 2;
   localparam int CMP_TWO_RESET_EN_BIT = 1;
   localparam int CMP_ONE_RESET_EN_BIT = 0;
   // Periodic pulse divider: shortest period is 2**DIV_BASE_LOG2 cycles.
   localparam int DIV_BASE_LOG2 = 2;
   localparam int DIV_CNT_W = 9;
   localparam logic [8:0] DIV_CNT_RST = 9'h000;
   // AHB-Lite encodings.
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [1:0] HTRANS_SEQ = 2'b11;
   localparam logic HRESP_OKAY = 1'b0;
endpackage

// *** src/srl_pulse_div.sv ***
`timescale 1ns/1ps
`default_nettype none
// Free-running divider making a one-cycle pulse every 4 to 512 cycles.
module srl_pulse_div (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Control
   input wire logic [2:0] periodic_pulse_divider_select,
   // Output
   output logic pulse
);
   logic [srl_pkg::DIV_CNT_W-1:0] cnt_q;
   logic [srl_pkg::DIV_CNT_W-1:0] mask;

   function automatic logic [srl_pkg::DIV_CNT_W-1:0] period_mask(input logic [2:0] sel);
      logic [srl_pkg::DIV_CNT_W:0] span;
      // The shift amount is four bits wide so that 2 + 7 does not wrap.
      span = (srl_pkg::DIV_CNT_W+1)'(1) << (4'(srl_pkg::DIV_BASE_LOG2) + {1'b0, sel});
      period_mask = srl_pkg::DIV_CNT_W'(span - 1'b1);
   endfunction

   assign mask = period_mask(periodic_pulse_divider_select);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cnt_q <= srl_pkg::DIV_CNT_RST;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign pulse = ((cnt_q & mask) == mask);

   a_pulse_period: assert property (@(posedge sys_clk) disable iff (reset)
      (periodic_pulse_divider_select == 3'b000 && $stable(periodic_pulse_divider_select)
       && pulse) |=> !pulse [*3] ##1 (pulse || periodic_pulse_divider_select != 3'b000))
      else $error("periodic pulse not every 4 cycles");
endmodule
`default_nettype wire

// *** src/srl_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for a bundle of asynchronous levels.
module srl_sync2 (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Levels
   input wire logic [2:0] async_in,
   output logic [2:0] sync_out
);
   logic [2:0] meta_q;
   logic [2:0] sync_q;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         meta_q <= 3'h0;
         sync_q <= 3'h0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule
`default_nettype wire

// *** testbench/set_reset_latch_module_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module set_reset_latch_module_tb;
   localparam logic [11:0] CT = srl_pkg::ADDR_CONTROL_MAIN;
   localparam logic [11:0] SE = srl_pkg::ADDR_SOURCE_ENABLES;
   localparam logic [11:0] ST = srl_pkg::ADDR_STATUS;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [2:0] want = 3'h0;
   wire logic [31:0] hrdata;
   wire logic hrdy, hresp, qp, qoe, np, noe, ext_in, c1, c2;
   logic [31:0] r, v;
   int num_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   int t0;
   int set_pos[3] = '{7, 5, 4};
   int rst_pos[3] = '{3, 1, 0};
   logic [7:0] wr[8] = '{8'h8e, 8'h8c, 8'h8d, 8'h8c, 8'h8e, 8'h8f, 8'h8e, 8'h8d};
   logic [31:0] ex[8] = '{32'h1, 32'h1, 32'h0, 32'h0, 32'h1, 32'h0, 32'h1, 32'h0};
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) cyc <= cyc + 1;
   srl_source_model src_u (.sys_clk(sys_clk), .want(want), .latch_external_input(ext_in),
      .synced_cmp_two_result(c2), .synced_cmp_one_result(c1));
   srl_latch_top dut_u (.sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
      .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .latch_external_input(ext_in),
      .synced_cmp_one_result(c1), .synced_cmp_two_result(c2), .latch_true_pin(qp),
      .latch_true_pin_oe(qoe), .latch_inverted_pin(np), .latch_inverted_pin_oe(noe));
   function automatic logic [31:0] rb(input logic [31:0] d);
      return {24'h0, d[7:2], 2'b00};
   endfunction
   function automatic logic [31:0] period(input int s);
      return 32'(4 << s);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= srl_pkg::HTRANS_NONSEQ;
      do @(posedge sys_clk); while (hrdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hrdy !== 1'b1);
      r = hrdata;
   endtask
   task automatic waitq(input logic lv);
      int n;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (qp !== lv && n < 700);
      if (n >= 700) chk({31'h0, qp}, {31'h0, lv});
   endtask
   task automatic conclude;
      $display("errors=%0d compared=%0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #1200000;
      num_errors++;
      conclude();
   end
   initial begin
      v = $urandom(32'hbddc);
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      chk({28'h0, qoe, noe, qp, np}, 32'h0);
      chk({30'h0, hrdy, hresp}, 32'h2);
      bus(0, CT, 0);
      chk(r, 32'h0);
      bus(0, 12'h00c, 0);
      chk(r, 32'h0);
      // Write-zero, stuck-pulse and both-at-once cases.
      for (int i = 0; i < 8; i++) begin
         bus(1, CT, {24'h0, wr[i]});
         // The latch moves one edge after the pulse, so let that edge pass first.
         @(posedge sys_clk);
         bus(0, ST, 0);
         chk(r, ex[i]);
         chk({28'h0, qoe, noe, qp, np}, {28'h0, 2'b11, ex[i][0], ~ex[i][0]});
      end
      bus(0, CT, 0);
      chk(r, 32'h8c);
      // The pin and each comparator are enabled one way at a time only.
      for (int i = 0; i < 3; i++) begin
         bus(1, CT, 32'h8d);
         bus(1, SE, 32'h1 << set_pos[i]);
         want <= 3'h1 << i;
         repeat (5) @(posedge sys_clk);
         bus(0, ST, 0);
         chk(r, 32'h1);
         want <= 3'h0;
         bus(1, SE, 32'h1 << rst_pos[i]);
         bus(0, ST, 0);
         chk(r, 32'h1);
         want <= 3'h1 << i;
         repeat (5) @(posedge sys_clk);
         bus(0, ST, 0);
         chk(r, 32'h0);
         bus(1, SE, 0);
         bus(1, CT, 32'h8e);
         repeat (5) @(posedge sys_clk);
         bus(0, ST, 0);
         chk(r, 32'h1);
         want <= 3'h0;
      end
      for (int k = 0; k < 8; k++) begin
         v = $urandom;
         bus(1, SE, v);
         bus(0, SE, 0);
         chk(r, {24'h0, v[7:0]});
         bus(1, CT, v >> 8);
         bus(0, CT, 0);
         chk(r, rb(v >> 8));
         chk({30'h0, qoe, noe}, {30'h0, v[15] & v[11], v[15] & v[10]});
      end
      // Pin holds set while the periodic pulse resets: one-cycle dips on the true pin.
      bus(1, SE, 32'h84);
      want <= 3'h1;
      for (int s = 0; s < 8; s++) begin
         bus(1, CT, 32'(32'h88 | (s << 4)));
         waitq(1'b0);
         waitq(1'b1);
         waitq(1'b0);
         t0 = cyc;
         waitq(1'b1);
         chk(32'(cyc - t0), 32'h1);
         waitq(1'b0);
         chk(32'(cyc - t0), period(s));
         @(posedge sys_clk);
      end
      conclude();
   end
endmodule
`default_nettype wire

// *** testbench/srl_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Stands in for the input pin and the two timer-synchronised comparators.
module srl_source_model (
   // Clock
   input wire logic sys_clk,
   // Requested levels: pin, comparator two, comparator one
   input wire logic [2:0] want,
   // Source levels
   output logic latch_external_input,
   output logic synced_cmp_two_result,
   output logic synced_cmp_one_result
);
   initial begin
      latch_external_input = 1'b0;
      synced_cmp_two_result = 1'b0;
      synced_cmp_one_result = 1'b0;
   end
   always @(posedge sys_clk) begin
      latch_external_input <= want[0];
      synced_cmp_two_result <= want[1];
      synced_cmp_one_result <= want[2];
   end
endmodule
`default_nettype wire
